/* core/sram_host_regs.vh */
`ifndef SRAM_HOST_REGS_VH
`define SRAM_HOST_REGS_VH
`define ADDR_W 15
`define DATA_W 8
`define CLK_PERIOD_PS 40000
// read access from select or address, ps
`define READ_ACCESS_PS 10000
// select to low-z output, ps
`define SELECT_TO_DRIVE_PS 3000
// deselect to float, ps
`define DESELECT_FLOAT_PS 5000
// strobe low to memory float, ps
`define STROBE_LOW_TO_FLOAT_PS 3500
// data setup to write end, ps
`define DATA_SETUP_PS 6500
// strobe width, output enable high and low, ps
`define STROBE_WIDTH_OUTPUTS_OFF_PS 7000
`define STROBE_WIDTH_OUTPUTS_ON_PS 10000
// retention entry setup and recovery (one read cycle), ps
`define RETENTION_ENTRY_SETUP_PS 0
`define RETENTION_RECOVERY_PS 10000
// least time to cycles, rounded up, at least one
`define CYC_MIN(t) ((((t) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS) < 1 ? 1 : \
   (((t) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS))
`endif

/* core/wait_timer.v */
`timescale 1ns/1ps
`default_nettype none
module wait_timer (
   // clock and reset
   input wire clk_sys,
   input wire rst,
   // control
   input wire start,
   input wire [3:0] cycles,
   output wire done
);
   reg [3:0] count;
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         count <= 4'h0;
      end else if (start) begin
         count <= cycles;
      end else if (count != 4'h0) begin
         count <= count - 4'h1;
      end
   end
   assign done = (count == 4'h0) && !start;
endmodule
`default_nettype wire

/* core/sram_host.v */
`timescale 1ns/1ps
`default_nettype none

`include "sram_host_regs.vh"

// Operation
// - host keeps write strobe high through every read
// - address valid by select fall; data within 10 ns, float 5 ns
// - write begins with select and strobe both active; raising select or strobe ends it
// - data setup timed against the edge that ends the write
// - write data stable 6.5 ns before the ending edge, no hold
// - strobe low at least 7 ns with output enable high
// - strobe low at least 10 ns with output enable low
// - deselect before supply drop; wait one read cycle after restore
module sram_host (
   // clock and reset
   input wire clk_sys,
   input wire rst,

   // user request
   input wire req_valid,
   input wire req_write,
   input wire [`ADDR_W-1:0] req_addr,
   input wire [`DATA_W-1:0] req_wdata,
   output wire req_ready,
   output reg [`DATA_W-1:0] rd_data,
   output reg rd_valid,

   // retention control
   input wire retain_req,
   input wire supply_good,
   output reg retain_active,

   // memory pins
   output reg [`ADDR_W-1:0] addr_in,
   output reg chip_select_n,
   output reg output_enable_n,
   output reg write_strobe_n,
   input wire [`DATA_W-1:0] data_io_in,
   output reg [`DATA_W-1:0] data_io_out,
   output reg data_io_oe_n
);

   // cycle counts worked out as integers, then cut to the timer width on purpose
   localparam integer RD_COUNT = `CYC_MIN(`READ_ACCESS_PS) + 1;
   localparam integer FLOAT_COUNT = `CYC_MIN(`DESELECT_FLOAT_PS);
   localparam integer WIDTH_COUNT = `CYC_MIN(`STROBE_WIDTH_OUTPUTS_OFF_PS);
   localparam integer SETUP_COUNT = `CYC_MIN(`DATA_SETUP_PS);
   localparam integer WR_COUNT = WIDTH_COUNT > SETUP_COUNT ? WIDTH_COUNT : SETUP_COUNT;
   localparam integer TURN_COUNT = `CYC_MIN(`STROBE_LOW_TO_FLOAT_PS);
   localparam integer RECOVER_COUNT = `CYC_MIN(`RETENTION_RECOVERY_PS);

   localparam [3:0] RD_CYC = RD_COUNT[3:0];
   localparam [3:0] FLOAT_CYC = FLOAT_COUNT[3:0];
   localparam [3:0] WR_CYC = WR_COUNT[3:0];
   localparam [3:0] TURN_CYC = TURN_COUNT[3:0];
   localparam [3:0] RECOVER_CYC = RECOVER_COUNT[3:0];

   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_READ = 3'h1;
   localparam [2:0] S_WTURN = 3'h2;
   localparam [2:0] S_WRITE = 3'h3;
   localparam [2:0] S_GAP = 3'h4;
   localparam [2:0] S_RETAIN = 3'h5;
   localparam [2:0] S_RECOVER = 3'h6;

   reg [2:0] state;
   reg [`DATA_W-1:0] din_meta;
   reg [`DATA_W-1:0] din_sync;
   reg [1:0] good_sync;

   reg tstart;
   reg [3:0] tcycles;
   wire tdone;

   // one shared down-counter paces every phase except S_IDLE and S_RETAIN, which wait on requests and on retain_req and supply
   wait_timer timer (
      .clk_sys(clk_sys),
      .rst(rst),
      .start(tstart),
      .cycles(tcycles),
      .done(tdone)
   );

   // read data sampled through two flops; read timer allows for them
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         din_meta <= 8'h00;
         din_sync <= 8'h00;
         good_sync <= 2'h0;
      end else begin
         din_meta <= data_io_in;
         din_sync <= din_meta;
         good_sync <= {good_sync[0], supply_good};
      end
   end

   // a pending retention request blocks new accesses
   assign req_ready = (state == S_IDLE) && !retain_req;

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state <= S_IDLE;
         addr_in <= 15'h0000;
         chip_select_n <= 1'b1;
         output_enable_n <= 1'b1;
         write_strobe_n <= 1'b1;
         data_io_out <= 8'h00;
         data_io_oe_n <= 1'b1;

         rd_data <= 8'h00;
         rd_valid <= 1'b0;
         retain_active <= 1'b0;

         tstart <= 1'b0;
         tcycles <= 4'h0;
      end else begin
         tstart <= 1'b0;
         rd_valid <= 1'b0;

         case (state)
            S_IDLE: begin
               if (retain_req) begin
                  // select is already high in idle; it only has to stay there
                  chip_select_n <= 1'b1;
                  retain_active <= 1'b1;
                  state <= S_RETAIN;
               end else if (req_valid) begin
                  addr_in <= req_addr;
                  chip_select_n <= 1'b0;
                  tstart <= 1'b1;
                  if (req_write) begin
                     // output enable stays high so the memory never drives
                     output_enable_n <= 1'b1;
                     write_strobe_n <= 1'b0;
                     data_io_out <= req_wdata;
                     tcycles <= TURN_CYC;
                     state <= S_WTURN;
                  end else begin
                     output_enable_n <= 1'b0;
                     write_strobe_n <= 1'b1;
                     tcycles <= RD_CYC;
                     state <= S_READ;
                  end
               end
            end

            S_READ: begin
               if (tdone && !tstart) begin
                  // rd_valid stands one cycle; rd_data holds until the next read
                  rd_data <= din_sync;
                  rd_valid <= 1'b1;
                  chip_select_n <= 1'b1;
                  output_enable_n <= 1'b1;
                  tcycles <= FLOAT_CYC;
                  tstart <= 1'b1;
                  state <= S_GAP;
               end
            end

            S_WTURN: begin
               if (tdone && !tstart) begin
                  // strobe went low first so the memory floats before the host drives
                  data_io_oe_n <= 1'b0;
                  tcycles <= WR_CYC;
                  tstart <= 1'b1;
                  state <= S_WRITE;
               end
            end

            S_WRITE: begin
               if (tdone && !tstart) begin
                  // strobe and select rise together to end the write; data released same edge
                  write_strobe_n <= 1'b1;
                  chip_select_n <= 1'b1;
                  data_io_oe_n <= 1'b1;
                  tcycles <= FLOAT_CYC;
                  tstart <= 1'b1;
                  state <= S_GAP;
               end
            end

            S_GAP: begin
               // gap covers the memory's float time before the next select
               if (tdone && !tstart) begin
                  state <= S_IDLE;
               end
            end

            S_RETAIN: begin
               // supply status comes from outside, so only the second flop is read
               if (!retain_req && good_sync[1]) begin
                  tcycles <= RECOVER_CYC;
                  tstart <= 1'b1;
                  state <= S_RECOVER;
               end
            end

            S_RECOVER: begin
               if (tdone && !tstart) begin
                  retain_active <= 1'b0;
                  state <= S_IDLE;
               end
            end

            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

/* test/sram_host_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sram_host_regs.vh"
module sram_host_checker (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // status and pins
   input wire logic rd_valid,
   input wire logic retain_active,
   input wire logic [`ADDR_W-1:0] addr_in,
   input wire logic chip_select_n,
   input wire logic output_enable_n,
   input wire logic write_strobe_n,
   input wire logic data_io_oe_n
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_read_no_strobe: assert property (!output_enable_n |-> write_strobe_n)
      else $error("strobe low in read");
   a_write_all_active: assert property (!write_strobe_n |-> !chip_select_n)
      else $error("strobe without select");
   a_drive_in_window: assert property (!data_io_oe_n |-> !write_strobe_n)
      else $error("host drives outside write");
   a_data_setup: assert property ($rose(write_strobe_n) |-> !$past(data_io_oe_n))
      else $error("no data before write end");
   a_bus_release: assert property ($rose(write_strobe_n) |->
      data_io_oe_n && $rose(chip_select_n)) else $error("bus held past write end");
   a_strobe_width: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*3])
      else $error("strobe too short");
   a_addr_held: assert property (!chip_select_n && !$fell(chip_select_n) |-> $stable(addr_in))
      else $error("address moved while selected");
   a_read_answer: assert property ($fell(chip_select_n) && write_strobe_n |->
      ##[2:8] rd_valid) else $error("read without answer");
   a_retain_deselect: assert property (retain_active |-> chip_select_n)
      else $error("selected in retention");
   cover property ($rose(rd_valid));
   cover property ($rose(write_strobe_n));
   cover property ($fell(retain_active));
endmodule
bind sram_host sram_host_checker chk_u (.clk_sys(clk_sys), .rst(rst), .rd_valid(rd_valid),
   .retain_active(retain_active), .addr_in(addr_in), .chip_select_n(chip_select_n),
   .output_enable_n(output_enable_n), .write_strobe_n(write_strobe_n),
   .data_io_oe_n(data_io_oe_n));
`default_nettype wire

/* test/sram_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sram_host_regs.vh"
module sram_model (
   // memory pins
   input wire logic [`ADDR_W-1:0] addr_in,
   input wire logic chip_select_n,
   input wire logic output_enable_n,
   input wire logic write_strobe_n,
   // data bus
   input wire logic host_drv,
   input wire logic [`DATA_W-1:0] din,
   output logic [`DATA_W-1:0] dout
);
   logic [`DATA_W-1:0] mem [0:32767];
   logic [`DATA_W-1:0] last = 8'h00;
   // host drive and data seen one setup time late: short setup leaves stale values at the end
   wire [`DATA_W-1:0] din_late;
   wire drv_late;
   assign #(`DATA_SETUP_PS / 1000.0) din_late = din;
   assign #(`DATA_SETUP_PS / 1000.0) drv_late = host_drv;
   wire drive = !chip_select_n && !output_enable_n && write_strobe_n;
   wire window = !chip_select_n && !write_strobe_n;
   always @* if (drive) last = mem[addr_in];
   // a floating bus shows the inverse of the last driven word
   assign #1 dout = drive ? mem[addr_in] : ~last;
   // the word is taken at the edge that ends the write window
   always @(negedge window) if (drv_late) mem[addr_in] = din_late;
endmodule
`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sram_host_regs.vh"
module tb_top;
   logic clk_sys = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0;
   logic retain_req = 1'b0, supply_good = 1'b1;
   logic [`ADDR_W-1:0] req_addr = 15'h0000;
   logic [`DATA_W-1:0] req_wdata = 8'h00;
   wire req_ready, rd_valid, retain_active, chip_select_n, output_enable_n, write_strobe_n;
   wire data_io_oe_n;
   wire [`ADDR_W-1:0] addr_in;
   wire [`DATA_W-1:0] rd_data, data_io_out, mem_dout;
   wire [`DATA_W-1:0] data_io = !data_io_oe_n ? data_io_out : mem_dout;
   logic [`DATA_W-1:0] ref_mem [int];
   logic [31:0] r;
   integer failures = 0, comparisons = 0, seed = 57, i;
   always #20 clk_sys = ~clk_sys;
   sram_host dut_u (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_write(req_write),
      .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rd_data(rd_data),
      .rd_valid(rd_valid), .retain_req(retain_req), .supply_good(supply_good),
      .retain_active(retain_active), .addr_in(addr_in), .chip_select_n(chip_select_n),
      .output_enable_n(output_enable_n), .write_strobe_n(write_strobe_n),
      .data_io_in(data_io), .data_io_out(data_io_out), .data_io_oe_n(data_io_oe_n));
   sram_model mem_u (.addr_in(addr_in), .chip_select_n(chip_select_n),
      .output_enable_n(output_enable_n), .write_strobe_n(write_strobe_n),
      .host_drv(!data_io_oe_n), .din(data_io), .dout(mem_dout));
   task results;
      if (failures == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task chk(input logic [`DATA_W-1:0] got, input logic [`DATA_W-1:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task op(input logic w, input logic [`ADDR_W-1:0] ad, input logic [`DATA_W-1:0] d);
      integer n;
      n = 0;
      @(negedge clk_sys);
      while (req_ready !== 1'b1) begin
         @(negedge clk_sys);
         n++;
         if (n > 50) begin chk(8'h00, 8'h01); results; end
      end
      req_valid = 1'b1; req_write = w; req_addr = ad; req_wdata = d;
      @(negedge clk_sys);
      req_valid = 1'b0;
      if (w) ref_mem[ad] = d;
      else begin
         while (rd_valid !== 1'b1) begin
            @(posedge clk_sys);
            #1;
            n++;
            if (n > 50) begin chk(8'h00, 8'h01); results; end
         end
         chk(rd_data, ref_mem[ad]);
      end
   endtask
   initial begin
      repeat (10) @(posedge clk_sys);
      @(negedge clk_sys);
      rst = 1'b0;
      op(1'b1, 15'h0000, 8'hA5);
      op(1'b1, 15'h7FFF, 8'h5A);
      op(1'b0, 15'h0000, 8'h00);
      op(1'b0, 15'h7FFF, 8'h00);
      for (i = 0; i < 16; i++) begin
         r = $random(seed);
         op(1'b1, r[14:0], r[22:15]);
         op(1'b0, r[14:0], 8'h00);
      end
      @(negedge clk_sys);
      retain_req = 1'b1;
      i = 0;
      while (retain_active !== 1'b1) begin
         @(negedge clk_sys);
         i++;
         if (i > 20) begin chk(8'h00, 8'h01); results; end
      end
      supply_good = 1'b0;
      repeat (4) @(negedge clk_sys);
      retain_req = 1'b0;
      repeat (4) @(negedge clk_sys);
      chk({7'h00, retain_active & chip_select_n & ~req_ready}, 8'h01);
      supply_good = 1'b1;
      i = 0;
      while (retain_active !== 1'b0) begin
         @(negedge clk_sys);
         i++;
         if (i > 20) begin chk(8'h00, 8'h01); results; end
      end
      op(1'b0, 15'h7FFF, 8'h00);
      results;
   end
endmodule
`default_nettype wire
